// >>> hw/acvp_in_chain.sv
// one input channel step: filter, offset, range classification and scaling
`timescale 1ns/1ps
`include "acvp_regs.svh"
module acvp_in_chain import acvp_pkg::*; (
   // sample and filter state
   input wire logic [15:0] raw,
   input wire logic [23:0] prev,
   // channel setup
   input wire acvp_in_cfg_t cfg,
   input wire logic [15:0] user_lo,
   input wire logic [15:0] user_hi,
   input wire logic [15:0] ofs,
   // results
   output logic [23:0] next_filt,
   output logic [15:0] value,
   output acvp_area_t area
);
   logic [3:0] k;
   logic signed [24:0] diff;
   logic signed [31:0] f, v, nlo, nhi, tlo, thi, elo, ehi;
   logic signed [63:0] u;

   always_comb
   begin
      // alpha = 1 - 2^-k; 8 fraction bits keep slow settings from stalling
      k = (cfg.filt == 3'h0) ? 4'h0 : {1'b0, cfg.filt} + 4'h1;
      diff = {raw[15], raw, 8'h00} - {prev[23], prev};
      next_filt = (k == 4'h0) ? {raw, 8'h00} : prev + 24'(diff >>> k);
      nlo = 32'sh0;
      nhi = `ACVP_NOM;
      unique case (cfg.range)
         IR_U10:
         begin
            tlo = -`ACVP_T1000; thi = `ACVP_T11000; elo = -`ACVP_E1250; ehi = `ACVP_E11250;
         end
         IR_U5_20MA:
         begin
            tlo = -`ACVP_T1000; thi = `ACVP_T11000; elo = -`ACVP_E5000; ehi = `ACVP_E15000;
         end
         IR_U1_4MA:
         begin
            tlo = -`ACVP_T800; thi = `ACVP_T10800; elo = -`ACVP_E4000; ehi = `ACVP_E14000;
         end
         IR_BIP10:
         begin
            nlo = -`ACVP_NOM; tlo = -`ACVP_T11000; thi = `ACVP_T11000;
            elo = -`ACVP_E11250; ehi = `ACVP_E11250;
         end
      endcase
      f = 32'($signed(next_filt[23:8]));
      v = acvp_clamp(f + 32'($signed(ofs)), elo, ehi);
      // tolerance bands are reported even with over/underflow checks off
      if (v > thi)
         area = cfg.ovf_en ? AR_OVER : AR_UP_TOL;
      else if (v > nhi)
         area = AR_UP_TOL;
      else if (v < tlo)
         area = cfg.unf_en ? AR_UNDER : AR_LO_TOL;
      else if (v < nlo)
         area = AR_LO_TOL;
      else
         area = AR_NOMINAL;
      u = 64'($signed(user_lo)) + (64'(v - nlo) * (64'($signed(user_hi)) - 64'($signed(user_lo))))
          / 64'(nhi - nlo);
      value = cfg.user_fmt ? acvp_sat16(u) : 16'(v);
   end
endmodule

// >>> hw/acvp_out_chain.sv
// one output channel: range check, saturation and converter codes
`timescale 1ns/1ps
`include "acvp_regs.svh"
module acvp_out_chain import acvp_pkg::*; (
   // set points
   input wire logic [15:0] setpoint,
   input wire logic [15:0] fallback,
   input wire acvp_out_cfg_t cfg,
   // codes and range flags
   output logic [11:0] set_code,
   output logic [11:0] fb_code,
   output logic [11:0] zero_code,
   output logic ovf,
   output logic unf
);
   logic signed [31:0] sp, lo, hi;

   function automatic logic [11:0] code_of(int v, acvp_orange_t r);
      int c;
      unique case (r)
         // signed base, or negative set points would wrap in unsigned arithmetic
         OR_BIP10: c = int'(`ACVP_DAC_MID) + v * `ACVP_DAC_HALF / `ACVP_E11250;
         OR_0_20MA: c = v * `ACVP_DAC_MAX / `ACVP_MA_SPAN;
         OR_4_20MA: c = (v * 16 + `ACVP_MA4_BIAS) * `ACVP_DAC_MAX / `ACVP_MA4_SPAN;
         default: c = 0;
      endcase
      return 12'(acvp_clamp(c, 0, `ACVP_DAC_MAX));
   endfunction

   always_comb
   begin
      sp = 32'($signed(setpoint));
      unique case (cfg.range)
         OR_0_20MA:
         begin
            lo = -`ACVP_T1000; hi = `ACVP_T11000;
         end
         OR_4_20MA:
         begin
            lo = -`ACVP_T800; hi = `ACVP_T10800;
         end
         default:
         begin
            lo = -`ACVP_T11000; hi = `ACVP_T11000;
         end
      endcase
      ovf = sp > hi;
      unf = sp < lo;
      set_code = code_of(acvp_clamp(sp, lo, hi), cfg.range);
      fb_code = code_of(acvp_clamp(32'($signed(fallback)), lo, hi), cfg.range);
      zero_code = (cfg.range == OR_BIP10) ? `ACVP_DAC_MID : 12'h000;
   end
endmodule

// >>> hw/acvp_top.sv
// analog channel value processor: one shared input chain for four channels, two output chains, AHB-Lite registers
`timescale 1ns/1ps
`include "acvp_regs.svh"
module acvp_top import acvp_pkg::*; #(
   parameter int MS_CYCLES = `ACVP_MS_CYCLES
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // converter samples and fault sources
   input wire acvp_sample_t sample,
   input wire acvp_fault_t fault,
   input wire logic [1:0] line_fault,
   // output converters and status
   output logic [1:0][11:0] dac_code,
   output logic [1:0] out_ovf,
   output logic [1:0] out_unf,
   output logic scan_done
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {SC_WAIT = 2'b01, SC_PROC = 2'b10} acvp_scan_t;

   typedef struct packed {
      acvp_scan_t fsm;
      logic [16:0] ms_cnt;
      logic [3:0] cyc_ms;
      logic [1:0] ch;
      logic done;
      logic fast;
      logic [3:0] use_mask;
      acvp_in_cfg_t [3:0] icfg;
      logic [3:0][15:0] ulo;
      logic [3:0][15:0] uhi;
      logic [3:0][15:0] ofs;
      logic [3:0] saved;
      logic [3:0][15:0] raw;
      logic [3:0][15:0] val;
      logic [3:0][23:0] filt;
      acvp_area_t [3:0] area;
      acvp_out_cfg_t [1:0] ocfg;
      logic [1:0][15:0] oset;
      logic [1:0][15:0] ofb;
      logic [1:0][11:0] code;
      logic [1:0] ovf;
      logic [1:0] unf;
      logic a_wr;
      logic [7:0] a_addr;
      logic [31:0] rdata;
      logic ready;
   } acvp_st_t;

   acvp_st_t s;
   acvp_st_t next_s;

   logic [23:0] ic_filt;
   logic [15:0] ic_val;
   acvp_area_t ic_area;
   logic [1:0][11:0] oc_set;
   logic [1:0][11:0] oc_fb;
   logic [1:0][11:0] oc_zero;
   logic [1:0] oc_ovf;
   logic [1:0] oc_unf;
   logic addr_ok;
   logic all_zero;
   logic [1:0] ri;
   logic [1:0] wi;

   function automatic logic [1:0] reg_idx(logic [7:0] a);
      return a[3:2];
   endfunction

   // module cycle length in milliseconds
   function automatic logic [3:0] scan_len(logic fast, logic [3:0] m);
      logic [3:0] n;
      n = `ACVP_FAST_BASE_MS;
      for (int i = 0; i < 4; i++)
         n = n + (m[i] ? `ACVP_FAST_CH_MS : 4'h0);
      return fast ? n : `ACVP_NORMAL_MS;
   endfunction

   // ----------------------------------------------------------------
   // processing chains
   // ----------------------------------------------------------------
   // one shared input chain, stepped through the channels once per cycle
   acvp_in_chain u_in (
      .raw(s.raw[s.ch]),
      .prev(s.filt[s.ch]),
      .cfg(s.icfg[s.ch]),
      .user_lo(s.ulo[s.ch]),
      .user_hi(s.uhi[s.ch]),
      .ofs(s.ofs[s.ch]),
      .next_filt(ic_filt),
      .value(ic_val),
      .area(ic_area)
   );

   for (genvar g = 0; g < 2; g++)
   begin : g_out
      acvp_out_chain u_out (
         .setpoint(s.oset[g]),
         .fallback(s.ofb[g]),
         .cfg(s.ocfg[g]),
         .set_code(oc_set[g]),
         .fb_code(oc_fb[g]),
         .zero_code(oc_zero[g]),
         .ovf(oc_ovf[g]),
         .unf(oc_unf[g])
      );
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      next_s.done = 1'b0;
      addr_ok = hsel & htrans[1] & hready;
      ri = reg_idx(haddr[7:0]);
      wi = reg_idx(s.a_addr);
      all_zero = fault.cfg_err | fault.int_err | fault.hot_swap | fault.reload | fault.pwr_down;

      // scan timing; filter base is the module cycle in both modes
      unique case (s.fsm)
         SC_WAIT:
         begin
            if (s.ms_cnt == 17'(MS_CYCLES - 1))
            begin
               next_s.ms_cnt = 17'h00000;
               if (s.cyc_ms + 4'h1 >= scan_len(s.fast, s.use_mask))
               begin
                  next_s.cyc_ms = 4'h0;
                  next_s.ch = 2'h0;
                  next_s.fsm = SC_PROC;
               end
               else
                  next_s.cyc_ms = s.cyc_ms + 4'h1;
            end
            else
               next_s.ms_cnt = s.ms_cnt + 17'h00001;
         end
         SC_PROC:
         begin
            next_s.ms_cnt = s.ms_cnt + 17'h00001;
            // fast cycle leaves unused channels untouched
            if (!s.fast || s.use_mask[s.ch])
            begin
               next_s.filt[s.ch] = ic_filt;
               next_s.val[s.ch] = ic_val;
               next_s.area[s.ch] = ic_area;
            end
            next_s.ch = s.ch + 2'h1;
            if (s.ch == 2'h3)
            begin
               next_s.fsm = SC_WAIT;
               next_s.done = 1'b1;
            end
         end
      endcase

      // newest converter sample per channel
      if (sample.valid)
         next_s.raw[sample.chan] = sample.value;

      // AHB-Lite address phase; zero wait state, data captured for the next cycle
      next_s.ready = 1'b1;
      next_s.a_wr = addr_ok & hwrite;
      next_s.a_addr = haddr[7:0];
      if (addr_ok && !hwrite)
      begin
         unique case (haddr[7:4])
            `ACVP_CTRL: next_s.rdata = (haddr[3:2] == 2'h0) ? {24'h0, s.use_mask, 3'h0, s.fast} : 32'h0;
            `ACVP_IN_CFG: next_s.rdata = {24'h0, s.icfg[ri]};
            `ACVP_IN_USER: next_s.rdata = {s.uhi[ri], s.ulo[ri]};
            `ACVP_IN_OFS: next_s.rdata = {15'h0, s.saved[ri], s.ofs[ri]};
            `ACVP_IN_VAL: next_s.rdata = {13'h0, s.area[ri], s.val[ri]};
            `ACVP_OUT_CS:
            begin
               if (haddr[3])
                  next_s.rdata = {14'h0, s.unf[ri[0]], s.ovf[ri[0]], s.oset[ri[0]]};
               else
                  next_s.rdata = {27'h0, s.ocfg[ri[0]]};
            end
            `ACVP_OUT_FB: next_s.rdata = (haddr[3] == 1'b0) ? {16'h0, s.ofb[ri[0]]} : 32'h0;
            default: next_s.rdata = 32'h0;
         endcase
      end

      // AHB-Lite data phase write
      if (s.a_wr)
      begin
         unique case (s.a_addr[7:4])
            `ACVP_CTRL:
            begin
               if (s.a_addr[3:2] == 2'h0)
               begin
                  next_s.fast = hwdata[`ACVP_CTRL_FAST];
                  next_s.use_mask = hwdata[`ACVP_CTRL_USE +: 4];
               end
            end
            // the filter state is kept, so a new setting just bends the next step
            `ACVP_IN_CFG: next_s.icfg[wi] = hwdata[7:0];
            `ACVP_IN_USER:
            begin
               next_s.ulo[wi] = hwdata[15:0];
               next_s.uhi[wi] = hwdata[31:16];
            end
            `ACVP_IN_OFS:
            begin
               // oversized offsets are limited, not refused
               next_s.ofs[wi] = 16'(acvp_clamp(32'($signed(hwdata[15:0])), -`ACVP_OFS_MAX,
                                               `ACVP_OFS_MAX));
               next_s.saved[wi] = 1'b1;
            end
            `ACVP_OUT_CS:
            begin
               if (s.a_addr[3])
                  next_s.oset[wi[0]] = hwdata[15:0];
               else
                  next_s.ocfg[wi[0]] = hwdata[4:0];
            end
            `ACVP_OUT_FB:
            begin
               if (!s.a_addr[3])
                  next_s.ofb[wi[0]] = hwdata[15:0];
            end
            // unmapped writes are dropped; read data of a back-to-back read must survive
            default:
            begin
               next_s.ready = 1'b1;
            end
         endcase
      end

      // output channels, most severe cause first
      for (int j = 0; j < 2; j++)
      begin
         next_s.ovf[j] = oc_ovf[j] & s.ocfg[j].flag_sel[0];
         next_s.unf[j] = oc_unf[j] & s.ocfg[j].flag_sel[1];
         if (all_zero)
            next_s.code[j] = oc_zero[j];
         else if (line_fault[j])
            next_s.code[j] = s.code[j];
         else if (fault.task_stop || fault.comm_lost)
            next_s.code[j] = s.ocfg[j].fb_en ? oc_fb[j] : s.code[j];
         else
            next_s.code[j] = oc_set[j];
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s <= '0;
         s.fsm <= SC_WAIT;
         s.use_mask <= `ACVP_USE_RST;
         s.ready <= 1'b1;
         s.code <= {`ACVP_DAC_MID, `ACVP_DAC_MID};
      end
      else
      begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign hrdata = s.rdata;
   assign hreadyout = s.ready;
   assign hresp = 1'b0;
   assign dac_code = s.code;
   assign out_ovf = s.ovf;
   assign out_unf = s.unf;
   assign scan_done = s.done;
endmodule

// >>> pkg/acvp_pkg.sv
// types and shared arithmetic of the channel processor
package acvp_pkg;
   typedef enum logic [1:0] {IR_U10 = 2'h0, IR_U5_20MA = 2'h1, IR_U1_4MA = 2'h2, IR_BIP10 = 2'h3} acvp_irange_t;
   typedef enum logic [1:0] {OR_BIP10 = 2'h0, OR_0_20MA = 2'h1, OR_4_20MA = 2'h2} acvp_orange_t;
   typedef enum logic [2:0] {AR_NOMINAL = 3'h0, AR_UP_TOL = 3'h1, AR_LO_TOL = 3'h2, AR_OVER = 3'h3,
                             AR_UNDER = 3'h4} acvp_area_t;
   typedef struct packed {
      logic unf_en;
      logic ovf_en;
      logic user_fmt;
      logic [2:0] filt;
      acvp_irange_t range;
   } acvp_in_cfg_t;
   typedef struct packed {
      logic fb_en;
      logic [1:0] flag_sel;
      acvp_orange_t range;
   } acvp_out_cfg_t;
   typedef struct packed {
      logic valid;
      logic [1:0] chan;
      logic signed [15:0] value;
   } acvp_sample_t;
   typedef struct packed {
      logic cfg_err;
      logic int_err;
      logic hot_swap;
      logic reload;
      logic pwr_down;
      logic task_stop;
      logic comm_lost;
   } acvp_fault_t;

   function automatic int acvp_clamp(int v, int lo, int hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   function automatic logic [15:0] acvp_sat16(longint v);
      return (v < -64'sd32768) ? 16'h8000 : ((v > 64'sd32767) ? 16'h7FFF : 16'(v));
   endfunction
endpackage

// >>> pkg/acvp_regs.svh
// register offsets, reset values, thresholds and timing counts of the channel processor
`ifndef ACVP_REGS_SVH
`define ACVP_REGS_SVH
`define ACVP_CLK_NS 10
`define ACVP_MS_NS 1000000
`define ACVP_MS_CYCLES (`ACVP_MS_NS / `ACVP_CLK_NS)
`define ACVP_NORMAL_MS 4'h5
`define ACVP_FAST_BASE_MS 4'h1
`define ACVP_FAST_CH_MS 4'h1
`define ACVP_CTRL 4'h0
`define ACVP_IN_CFG 4'h1
`define ACVP_IN_USER 4'h2
`define ACVP_IN_OFS 4'h3
`define ACVP_IN_VAL 4'h4
`define ACVP_OUT_CS 4'h5
`define ACVP_OUT_FB 4'h6
`define ACVP_CTRL_FAST 0
`define ACVP_CTRL_USE 4
`define ACVP_USE_RST 4'hF
`define ACVP_DAC_MID 12'h800
`define ACVP_DAC_MAX 32'sh00000FFF
`define ACVP_DAC_HALF 32'sh000007FF
`define ACVP_NOM 32'sh00002710
`define ACVP_T1000 32'sh000003E8
`define ACVP_T11000 32'sh00002AF8
`define ACVP_T800 32'sh00000320
`define ACVP_T10800 32'sh00002A30
`define ACVP_E1250 32'sh000004E2
`define ACVP_E11250 32'sh00002BF2
`define ACVP_E5000 32'sh00001388
`define ACVP_E15000 32'sh00003A98
`define ACVP_E4000 32'sh00000FA0
`define ACVP_E14000 32'sh000036B0
`define ACVP_OFS_MAX 32'sh000005DC
`define ACVP_MA_SPAN 32'sh00002EE0
`define ACVP_MA4_BIAS 32'sh00009C40
`define ACVP_MA4_SPAN 32'sh0003A980
`endif

// >>> verif/acvp_conv_model.sv
// converter model: feeds raw samples of the four input channels in turn
`timescale 1ns/1ps
module acvp_conv_model import acvp_pkg::*; (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // raw values and sample stream
   input wire logic [3:0][15:0] vals,
   output acvp_sample_t sample
);
   logic [1:0] ch;
   // one channel per cycle, so every channel refreshes well inside a scan
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ch <= 2'h0;
         sample <= '0;
      end
      else
      begin
         ch <= ch + 2'h1;
         sample <= '{valid: 1'b1, chan: ch, value: vals[ch]};
      end
   end
endmodule

// >>> verif/acvp_properties.sv
// concurrent checks on the channel processor ports
`timescale 1ns/1ps
module acvp_chk import acvp_pkg::*; #(
   parameter int MS_CYCLES = 10
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // watched ports
   input wire acvp_fault_t fault,
   input wire logic [1:0] line_fault,
   input wire logic [1:0][11:0] dac_code,
   input wire logic [1:0] out_ovf,
   input wire logic [1:0] out_unf,
   input wire logic scan_done
);
   logic zf;
   int unsigned gap;
   assign zf = fault.cfg_err | fault.int_err | fault.hot_swap | fault.reload | fault.pwr_down;
   // cycles since the last scan end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         gap <= 0;
      else
         gap <= scan_done ? 0 : gap + 1;
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   zero_out_a: assert property (zf |=> dac_code[0] inside {12'h800, 12'h000}
      && dac_code[1] inside {12'h800, 12'h000})
      else $error("outputs not zero under severe fault");
   pwr_zero_a: assert property ($rose(hresetn) |-> dac_code == {12'h800, 12'h800} && !scan_done)
      else $error("outputs not zero after reset");
   hold_ch0_a: assert property (line_fault[0] && !zf |=> $stable(dac_code[0]))
      else $error("channel 0 moved during line fault");
   hold_ch1_a: assert property (line_fault[1] && !zf |=> $stable(dac_code[1]))
      else $error("channel 1 moved during line fault");
   flag_excl_a: assert property ((out_ovf & out_unf) == 2'h0)
      else $error("overflow and underflow flagged together");
   scan_pulse_a: assert property (scan_done |=> !scan_done [*8])
      else $error("scan end repeated too soon");
   scan_max_a: assert property (gap <= 5 * MS_CYCLES + 8)
      else $error("scan cycle too long");
   scan_min_a: assert property (scan_done |-> gap >= MS_CYCLES - 2)
      else $error("scan cycle too short");
endmodule
bind acvp_top acvp_chk #(.MS_CYCLES(MS_CYCLES)) i_chk (.hclk(hclk), .hresetn(hresetn), .fault(fault),
   .line_fault(line_fault), .dac_code(dac_code), .out_ovf(out_ovf), .out_unf(out_unf), .scan_done(scan_done));

// >>> verif/acvp_top_tb.sv
// self-checking bench of the channel processor
`timescale 1ns/1ps
module acvp_top_tb import acvp_pkg::*;;
   localparam int MS = 10;
   // input cases: cfg, raw, offset, value, area
   localparam int IC[15][5] = '{'{192, 5000, 0, 5000, 0}, '{192, 10500, 0, 10500, 1}, '{192, 11200, 0, 11200, 3},
      '{128, 11200, 0, 11200, 1}, '{192, -500, 0, -500, 2}, '{192, -1200, 0, -1200, 4}, '{192, 30000, 0, 11250, 3},
      '{193, 14000, 0, 14000, 3}, '{194, 10900, 0, 10900, 3}, '{195, -10500, 0, -10500, 2},
      '{195, -12000, 0, -11250, 4}, '{192, 9000, 1500, 10500, 1}, '{192, -1000, -1500, -1250, 4},
      '{224, 5000, 0, 6400, 0}, '{224, -1000, 0, 2560, 2}};
   // output cases: channel, cfg, set point
   localparam int OC[9][3] = '{'{0, 12, 11200}, '{0, 12, -11250}, '{0, 13, -500}, '{0, 13, 12000},
      '{0, 14, -1600}, '{0, 14, 5000}, '{1, 4, -11100}, '{1, 8, 11100}, '{1, 12, 3000}};
   logic hclk = 0;
   logic hresetn = 0;
   logic hsel = 0;
   logic hwrite = 0;
   logic rd_ph = 0;
   logic look = 0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [1:0] line_fault = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [3:0][15:0] vals = '0;
   acvp_fault_t fault = '0;
   acvp_sample_t sample;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic scan_done;
   logic [1:0][11:0] dac_code;
   logic [1:0] out_ovf;
   logic [1:0] out_unf;
   logic [31:0] rq[$];
   logic [31:0] dq[$];
   int n_fail = 0;
   int n_tests = 0;
   int r[2] = '{0, 0};
   int f[2] = '{0, 0};
   int s[2] = '{0, 0};
   int n;
   int o;

   always #5 hclk = ~hclk;

   acvp_top #(.MS_CYCLES(MS)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .sample(sample), .fault(fault), .line_fault(line_fault), .dac_code(dac_code),
      .out_ovf(out_ovf), .out_unf(out_unf), .scan_done(scan_done));
   acvp_conv_model i_conv (.hclk(hclk), .hresetn(hresetn), .vals(vals), .sample(sample));

   // ----------------------------------------
   // checking and closing
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // monitor: oldest note against what the outputs show
   always @(posedge hclk)
   begin
      if (rd_ph && hreadyout === 1'b1)
      begin
         chk(hrdata, rq.pop_front());
         chk({31'h0, hresp}, 32'h0);
      end
      if (look)
         chk({4'h0, out_unf, out_ovf, dac_code}, dq.pop_front());
   end

   // ----------------------------------------
   // bus and wait tasks
   // ----------------------------------------
   // bounded wait for ready (sel 0) or scan end (sel 1)
   task automatic waitfor(input bit sel, output int k);
      k = 0;
      do
      begin
         @(posedge hclk);
         k++;
      end
      while ((sel ? scan_done : hreadyout) !== 1'b1 && k < 900);
      if (k >= 900)
      begin
         n_fail++;
         final_report();
      end
   endtask

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      waitfor(0, k);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0;
      rd_ph <= !w;
      waitfor(0, k);
      rd_ph <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask

   task automatic obs(input logic [31:0] e);
      dq.push_back(e);
      @(posedge hclk);
      look <= 1'b1;
      @(posedge hclk);
      look <= 1'b0;
   endtask

   // ----------------------------------------
   // expected values
   // ----------------------------------------
   function automatic int code(input int rr, input int v);
      int lo;
      int hi;
      lo = rr == 0 ? -11000 : rr == 1 ? -1000 : -800;
      hi = rr == 2 ? 10800 : 11000;
      v = v < lo ? lo : v > hi ? hi : v;
      v = rr == 0 ? 2048 + v * 2047 / 11250 : rr == 1 ? v * 4095 / 12000 : (16 * v + 40000) * 4095 / 240000;
      return v < 0 ? 0 : v > 4095 ? 4095 : v;
   endfunction

   function automatic logic [31:0] oexp(input int c0, input int c1);
      logic [1:0] ov;
      logic [1:0] un;
      for (int j = 0; j < 2; j++)
      begin
         ov[j] = f[j][0] && s[j] > (r[j] == 2 ? 10800 : 11000);
         un[j] = f[j][1] && s[j] < (r[j] == 0 ? -11000 : r[j] == 1 ? -1000 : -800);
      end
      return {4'h0, un, ov, 12'(c1), 12'(c0)};
   endfunction

   task automatic onom();
      obs(oexp(code(r[0], s[0]), code(r[1], s[1])));
   endtask

   task automatic oset(input int j, input int c, input int p);
      r[j] = c & 3;
      f[j] = (c >> 2) & 3;
      s[j] = p;
      wr(8'(8'h50 + 4 * j), 32'(c));
      wr(8'(8'h58 + 4 * j), 32'(p) & 32'h0000FFFF);
   endtask

   // two scan ends so the sample and offset are both in
   task automatic inchk(input int c, input int raw, input int ofs, input int v, input int a);
      int k;
      wr(8'h10, 32'(c));
      wr(8'h30, 32'(ofs) & 32'h0000FFFF);
      vals[0] <= 16'(raw);
      waitfor(1, k);
      waitfor(1, k);
      rd(8'h40, {13'h0, 3'(a), 16'(v)});
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      void'($urandom(32'hE309F4D5));
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd(8'h00, 32'h000000F0);
      wr(8'h80, 32'hFFFFFFFF);
      rd(8'h80, 32'h00000000);
      obs(oexp(2048, 2048));
      waitfor(1, n);
      waitfor(1, n);
      chk(32'(n >= 5 * MS && n <= 5 * MS + 8), 32'h1);
      wr(8'h00, 32'h00000011);
      waitfor(1, n);
      waitfor(1, n);
      chk(32'(n >= 2 * MS && n <= 2 * MS + 8), 32'h1);
      wr(8'h14, 32'h000000C3);
      wr(8'h34, 32'h00000BB8);
      rd(8'h34, 32'h000105DC);
      wr(8'h34, 32'h0000F448);
      rd(8'h34, 32'h0001FA24);
      rd(8'h14, 32'h000000C3);
      rd(8'h38, 32'h00000000);
      o = int'($urandom_range(3000)) - 1500;
      wr(8'h3C, 32'(o) & 32'h0000FFFF);
      rd(8'h3C, {15'h0, 1'b1, 16'(o)});
      wr(8'h20, 32'h25800C80);
      foreach (IC[i])
         inchk(IC[i][0], IC[i][1], IC[i][2], IC[i][3], IC[i][4]);
      for (int q = 1; q < 7; q++)
      begin
         inchk(192, 0, 0, 0, 0);
         wr(8'h10, 32'(192 | (q << 2)));
         vals[0] <= 16'h2800;
         waitfor(1, n);
         rd(8'h40, 32'(10240 >> (q + 1)));
      end
      foreach (OC[i])
      begin
         oset(OC[i][0], OC[i][1], OC[i][2]);
         onom();
      end
      // random set point, also beyond both limits
      oset(1, 12, int'($urandom_range(24000)) - 12000);
      onom();
      oset(1, 12, 3000);
      // one edge so the new set point reaches the code before the hold starts
      @(posedge hclk);
      line_fault <= 2'h3;
      oset(0, 14, 8000);
      oset(1, 12, -3000);
      obs(oexp(code(2, 5000), code(0, 3000)));
      line_fault <= 2'h0;
      onom();
      wr(8'h60, 32'h00002710);
      oset(0, 30, 8000);
      fault.task_stop <= 1'b1;
      oset(1, 12, 6000);
      obs(oexp(code(2, 10000), code(0, -3000)));
      wr(8'h60, 32'h000007D0);
      obs(oexp(code(2, 2000), code(0, -3000)));
      for (int b = 2; b < 7; b++)
      begin
         fault <= acvp_fault_t'(7'(7'h1 << b));
         obs(oexp(0, 2048));
      end
      // hold after a zero phase keeps the zero code
      fault <= acvp_fault_t'(7'h01);
      obs(oexp(code(2, 2000), 2048));
      fault <= '0;
      onom();
      final_report();
   end

   initial
   begin
      #1000000;
      n_fail++;
      final_report();
   end
endmodule
